// ### design/nvm_seq_cfg.svh
`ifndef NVM_SEQ_CFG_SVH
`define NVM_SEQ_CFG_SVH

// Function
// - Loader writes code and data; code writes data.
// - Out-of-range section end fuse falls back to default.
// - Loader lock hides loader after execution leaves it.
// - Code write-protect bit refuses further code updates.
// - EEPROM updates only bytes marked in buffer.
// - User row survives full wipe; debug may write.
// - Array loads stall while an operation runs.
// - Stores AND-merge into shared page buffer.
// - Buffer returns to ones after reset, ops, wake.
// - Command needs unlock key within four cycles.
// - Page write; flash halts core; buffer cleared.
// - Page wipe needs marked byte; buffer cleared.
// - Combined wipe then program, buffer kept between.
// - Buffer reset halts core seven cycles.
// - Full wipe ignores lock bits, honours keep fuse.
// - Full wipe keeps fuses and brownout enabled.
// - EEPROM wipe halts core until done.
// - Fuse programming from debug interface only.
// - After power-on, writes refused, busy flags set.
// - Holdoff skipped by fuse zero or debug pin.
// - Three-bit command codes zero through seven.
// - Ready flag held while EEPROM idle; write-one clears.
// - Write fault reports last operation's rejection.

`define IDX_CMD 6'h00
`define IDX_PROT 6'h01
`define IDX_STATUS 6'h02
`define IDX_FLAGS 6'h04
`define IDX_DATA 6'h06
`define IDX_ADDR 6'h08
`define IDX_GUARD 6'h0a

`define PROT_WP_BIT 0
`define PROT_LOCK_BIT 1
`define STATUS_FLASH_BUSY_FLAG_BIT 0
`define STATUS_EEPROM_BUSY_FLAG_BIT 1
`define STATUS_FAULT_BIT 2
`define FLAG_READY_BIT 0

`define KEY_CMD 8'h5a
`define KEY_PROT 8'ha5
`define GUARD_WINDOW 3'h4
`define CLEAR_CYCLES 16'h0007

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define PAGE_BITS 5
`define PAGE_BYTES 32
`define BYTE_ONES 8'hff
`define LOADER_END_DEFAULT 8'h00
`define CODE_END_DEFAULT 8'h00
`define LAST_FLASH_ADDRESS 16'h1fff
`define FLASH_BASE 16'h8000
`define EE_BASE 16'h1400
`define EE_TOP 16'h147f
`define ROW_BASE 16'h1300
`define ROW_TOP 16'h131f

`define CLK_MHZ 10
`define HOLDOFF_US 1000

`endif

// ### design/nvm_seq_pkg.sv
package nvm_seq_pkg;

	typedef enum logic [2:0] {
		ST_START, ST_HOLD, ST_IDLE, ST_CLR, ST_ARRAY
	} seq_state_e;

	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_PAGE_PROGRAM = 3'h1,
		CMD_PAGE_WIPE = 3'h2,
		CMD_PAGE_WIPE_PROGRAM = 3'h3,
		CMD_BUFFER_RESET = 3'h4,
		CMD_FULL_ARRAY_WIPE = 3'h5,
		CMD_EEPROM_WIPE = 3'h6,
		CMD_FUSE_PROGRAM = 3'h7
	} nvm_cmd_e;

	typedef enum logic [1:0] {
		KIND_NONE, KIND_FLASH, KIND_EEPROM, KIND_ROW
	} mem_kind_e;

	typedef enum logic [1:0] {SEC_LOADER, SEC_CODE, SEC_DATA} section_e;

	typedef enum logic [2:0] {
		OP_PAGE_ERASE, OP_PAGE_PROGRAM, OP_FULL, OP_EEPROM_ALL, OP_FUSE
	} array_op_e;

	typedef struct packed {
		logic [7:0] loaderEnd;
		logic [7:0] codeEnd;
		logic keepEeprom;
		logic holdoffDisable;
		logic resetPinDebug;
		logic brownoutEnabled;
	} fuse_s;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [7:0] data;
	} store_s;

	typedef struct packed {
		logic [7:0] data;
		logic mark;
	} byte_state_s;

	typedef struct packed {
		seq_state_e st;
		logic [15:0] cnt;
		logic erThenProg;
		logic [2:0] guardCmd;
		logic [2:0] guardProt;
		logic [2:0] cmdCode;
		logic lockPend;
		logic lockActive;
		logic codeWp;
		logic fault;
		logic eeprom_busy_flag;
		logic flash_busy_flag;
		logic readyFlag;
		logic [15:0] dataWord;
		logic [15:0] addrWord;
		mem_kind_e bufKind;
		logic [15:0] bufPage;
		logic bufMixed;
		logic cpuHalt;
		logic readStall;
		logic bodHold;
		logic arrayReq;
		array_op_e arrayOp;
		mem_kind_e arrayKind;
		logic [15:0] arrayAddr;
		logic [31:0] arrayMask;
		logic [7:0] arrayData;
		logic arrayKeepEe;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} seq_state_s;

endpackage

// ### design/page_buffer_byte.sv
`include "nvm_seq_cfg.svh"

module page_buffer_byte
	import nvm_seq_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic clear,
	input wire logic load,
	input wire logic [7:0] din,
	output logic [7:0] dout,
	output logic marked
);

	byte_state_s r_reg;
	byte_state_s r_next;

	always_comb begin
		r_next = r_reg;
		if (clear) begin
			r_next.data = `BYTE_ONES;
			r_next.mark = 1'b0;
		end else if (load) begin
			r_next.data = r_reg.data & din;
			r_next.mark = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r_reg <= '{data: `BYTE_ONES, mark: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign dout = r_reg.data;
	assign marked = r_reg.mark;

	a_merge_and_data:
	assert property (@(posedge clk) disable iff (!nrst)
		load && !clear |=> dout == ($past(dout) & $past(din)))
	else $error("Page buffer byte did not AND-merge.");

endmodule

// ### design/nonvolatile_memory_sequencer.sv
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`include "nvm_seq_cfg.svh"

module nonvolatile_memory_sequencer
	import nvm_seq_pkg::*;
#(
	parameter int HOLDOFF_CYCLES = `HOLDOFF_US * `CLK_MHZ
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire fuse_s fuses,
	input wire logic porReset,
	input wire logic dbgActive,
	input wire logic deviceLocked,
	input wire logic wakeUp,
	input wire logic [12:0] pcOff,
	input wire store_s store,
	input wire logic arrayDone,
	input wire logic [4:0] arrayIdx,
	output logic cpuHalt,
	output logic readStall,
	output logic loaderBlocked,
	output logic bodHold,
	output logic arrayReq,
	output array_op_e arrayOp,
	output mem_kind_e arrayKind,
	output logic [15:0] arrayAddr,
	output logic [15:0] arrayWord,
	output logic [31:0] arrayMask,
	output logic [7:0] arrayData,
	output logic arrayKeepEe
);

	////////////////////////////////////////////////////////////////////////
	localparam logic [15:0] HOLD_LAST = 16'(HOLDOFF_CYCLES - 1);
	localparam logic [15:0] FLASH_TOP = `FLASH_BASE + `LAST_FLASH_ADDRESS;
	localparam logic [15:0] PAGE_MASK = ~16'(`PAGE_BYTES - 1);
	localparam seq_state_s RESET_STATE = '{st: ST_START,
		bufKind: KIND_NONE, arrayKind: KIND_NONE, arrayOp: OP_PAGE_ERASE,
		eeprom_busy_flag: 1'b1, flash_busy_flag: 1'b1, default: '0};

	seq_state_s r_reg;
	seq_state_s r_next;
	logic [7:0] bufBytes [`PAGE_BYTES];
	logic [`PAGE_BYTES-1:0] marks;
	logic [`PAGE_BYTES-1:0] bufLoad;
	logic clrBuf;
	logic clearReady;
	logic cmdGo;
	logic launch;
	array_op_e launchOp;
	mem_kind_e launchKind;
	nvm_cmd_e cmd;
	section_e execSec;
	mem_kind_e stKind;
	logic [15:0] stPage;

	////////////////////////////////////////////////////////////////////////
	// An end fuse beyond the array is ignored in favour of the default.
	function automatic logic [7:0] effEnd(input logic [7:0] f,
		input logic [7:0] dflt);
		if ({f, 8'h00} > `LAST_FLASH_ADDRESS + 16'h0001) begin
			return dflt;
		end
		return f;
	endfunction

	function automatic section_e sectionOf(input logic [15:0] a);
		logic [15:0] off;
		logic [7:0] be;
		logic [7:0] ce;
		section_e s;
		off = a - `FLASH_BASE;
		be = effEnd(fuses.loaderEnd, `LOADER_END_DEFAULT);
		ce = effEnd(fuses.codeEnd, `CODE_END_DEFAULT);
		if (be == 8'h00 || off[15:8] < be) begin
			s = SEC_LOADER;
		end else if (ce == 8'h00) begin
			s = SEC_CODE;
		end else if (ce <= be || off[15:8] >= ce) begin
			s = SEC_DATA;
		end else begin
			s = SEC_CODE;
		end
		return s;
	endfunction

	function automatic mem_kind_e kindOf(input logic [15:0] a);
		mem_kind_e k;
		k = KIND_NONE;
		if (a >= `FLASH_BASE && a <= FLASH_TOP) begin
			k = KIND_FLASH;
		end else if (a >= `EE_BASE && a <= `EE_TOP) begin
			k = KIND_EEPROM;
		end else if (a >= `ROW_BASE && a <= `ROW_TOP) begin
			k = KIND_ROW;
		end
		return k;
	endfunction

	// A locked device still lets the debug side reach the user row.
	function automatic logic denied(input mem_kind_e k,
		input logic [15:0] a);
		logic d;
		section_e s;
		s = sectionOf(a);
		d = (k == KIND_FLASH) && (s == SEC_CODE) && r_reg.codeWp;
		if (dbgActive) begin
			d = d | (deviceLocked && k != KIND_ROW);
		end else begin
			d = d | (execSec == SEC_DATA);
			d = d | ((k == KIND_FLASH) && (s == SEC_LOADER ||
				(s == SEC_CODE && execSec != SEC_LOADER)));
		end
		return d;
	endfunction

	assign execSec = sectionOf(`FLASH_BASE | {3'h0, pcOff});
	assign stKind = kindOf(store.addr);
	assign stPage = store.addr & PAGE_MASK;
	assign cmd = nvm_cmd_e'(wdata[2:0]);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		r_next = r_reg;
		clrBuf = 1'b0;
		bufLoad = '0;
		clearReady = 1'b0;
		cmdGo = 1'b0;
		launch = 1'b0;
		launchOp = OP_PAGE_PROGRAM;
		launchKind = KIND_FLASH;
		r_next.arrayReq = 1'b0;
		r_next.awready = 1'b0;
		r_next.wready = 1'b0;
		r_next.arready = 1'b0;
		r_next.arrayData = bufBytes[arrayIdx];
		if (r_reg.guardCmd != 3'h0) begin
			r_next.guardCmd = r_reg.guardCmd - 3'h1;
		end
		if (r_reg.guardProt != 3'h0) begin
			r_next.guardProt = r_reg.guardProt - 3'h1;
		end
		// The lock waits until the loader is left, so the loader itself
		// can finish its work after setting it.
		r_next.lockActive = r_reg.lockActive |
			(r_reg.lockPend & (execSec != SEC_LOADER));
		if (r_reg.bvalid && bready) begin
			r_next.bvalid = 1'b0;
		end
		if (r_reg.rvalid && rready) begin
			r_next.rvalid = 1'b0;
		end
		if (arvalid && !r_reg.rvalid && !r_reg.arready) begin
			r_next.arready = 1'b1;
			r_next.rvalid = 1'b1;
			r_next.rresp = `RESP_OKAY;
			r_next.rdata = '0;
			case (araddr[7:2])
				`IDX_CMD: r_next.rdata[2:0] = r_reg.cmdCode;
				`IDX_PROT: r_next.rdata[1:0] = {r_reg.lockPend, r_reg.codeWp};
				`IDX_STATUS: r_next.rdata[2:0] =
					{r_reg.fault, r_reg.eeprom_busy_flag, r_reg.flash_busy_flag};
				`IDX_FLAGS: r_next.rdata[`FLAG_READY_BIT] = r_reg.readyFlag;
				`IDX_DATA: r_next.rdata[15:0] = r_reg.dataWord;
				`IDX_ADDR: r_next.rdata[15:0] = r_reg.addrWord;
				`IDX_GUARD: ;
				default: r_next.rresp = `RESP_SLVERR;
			endcase
		end
		if (awvalid && wvalid && !r_reg.bvalid && !r_reg.awready) begin
			r_next.awready = 1'b1;
			r_next.wready = 1'b1;
			r_next.bvalid = 1'b1;
			r_next.bresp = `RESP_OKAY;
			case (awaddr[7:2])
				`IDX_GUARD: if (wstrb[0]) begin
					if (wdata[7:0] == `KEY_CMD) begin
						r_next.guardCmd = `GUARD_WINDOW;
					end else if (wdata[7:0] == `KEY_PROT) begin
						r_next.guardProt = `GUARD_WINDOW;
					end
				end
				`IDX_PROT: if (wstrb[0] && r_reg.guardProt != 3'h0) begin
					r_next.guardProt = 3'h0;
					if (wdata[`PROT_WP_BIT]) begin
						r_next.codeWp = 1'b1;
					end
					if (wdata[`PROT_LOCK_BIT] && execSec == SEC_LOADER) begin
						r_next.lockPend = 1'b1;
					end
				end
				`IDX_CMD: if (wstrb[0] && r_reg.guardCmd != 3'h0) begin
					r_next.guardCmd = 3'h0;
					cmdGo = 1'b1;
				end
				`IDX_FLAGS: clearReady = wstrb[0] & wdata[`FLAG_READY_BIT];
				`IDX_DATA: begin
					if (wstrb[0]) r_next.dataWord[7:0] = wdata[7:0];
					if (wstrb[1]) r_next.dataWord[15:8] = wdata[15:8];
				end
				`IDX_ADDR: begin
					if (wstrb[0]) r_next.addrWord[7:0] = wdata[7:0];
					if (wstrb[1]) r_next.addrWord[15:8] = wdata[15:8];
				end
				`IDX_STATUS: ;
				default: r_next.bresp = `RESP_SLVERR;
			endcase
		end
		case (r_reg.st)
			ST_START: begin
				if (porReset && fuses.holdoffDisable &&
					!fuses.resetPinDebug) begin
					r_next.st = ST_HOLD;
					r_next.cnt = HOLD_LAST;
				end else begin
					r_next.st = ST_IDLE;
					r_next.flash_busy_flag = 1'b0;
					r_next.eeprom_busy_flag = 1'b0;
				end
			end
			ST_HOLD: begin
				if (r_reg.cnt == 16'h0000) begin
					r_next.st = ST_IDLE;
					r_next.flash_busy_flag = 1'b0;
					r_next.eeprom_busy_flag = 1'b0;
				end else begin
					r_next.cnt = r_reg.cnt - 16'h0001;
				end
			end
			ST_IDLE: begin
				if (wakeUp) begin
					clrBuf = 1'b1;
				end else if (cmdGo) begin
					r_next.cmdCode = wdata[2:0];
					r_next.fault = 1'b0;
					case (cmd)
						CMD_PAGE_PROGRAM, CMD_PAGE_WIPE,
						CMD_PAGE_WIPE_PROGRAM: begin
							if (r_reg.bufMixed ||
								denied(r_reg.bufKind, r_reg.bufPage)) begin
								r_next.fault = 1'b1;
							end else if (r_reg.bufKind != KIND_NONE) begin
								launch = 1'b1;
								launchKind = r_reg.bufKind;
								launchOp = (cmd == CMD_PAGE_PROGRAM) ?
									OP_PAGE_PROGRAM : OP_PAGE_ERASE;
								r_next.erThenProg =
									(cmd == CMD_PAGE_WIPE_PROGRAM);
							end
						end
						CMD_BUFFER_RESET: begin
							r_next.st = ST_CLR;
							r_next.cnt = `CLEAR_CYCLES - 16'h0001;
							r_next.cpuHalt = 1'b1;
							clrBuf = 1'b1;
						end
						CMD_FULL_ARRAY_WIPE, CMD_EEPROM_WIPE: begin
							if (!dbgActive && execSec == SEC_DATA) begin
								r_next.fault = 1'b1;
							end else begin
								launch = 1'b1;
								launchOp = (cmd == CMD_FULL_ARRAY_WIPE) ?
									OP_FULL : OP_EEPROM_ALL;
								launchKind = (cmd == CMD_FULL_ARRAY_WIPE) ?
									KIND_FLASH : KIND_EEPROM;
							end
						end
						CMD_FUSE_PROGRAM: begin
							if (!dbgActive) begin
								r_next.fault = 1'b1;
							end else begin
								launch = 1'b1;
								launchOp = OP_FUSE;
								launchKind = KIND_NONE;
							end
						end
						default: ;
					endcase
				end else if (store.valid && stKind != KIND_NONE) begin
					if (denied(stKind, store.addr)) begin
						r_next.fault = 1'b1;
					end else begin
						bufLoad[store.addr[`PAGE_BITS-1:0]] = 1'b1;
						if (r_reg.bufKind != KIND_NONE &&
							(r_reg.bufKind != stKind ||
							r_reg.bufPage != stPage)) begin
							r_next.bufMixed = 1'b1;
						end
						r_next.bufKind = stKind;
						r_next.bufPage = stPage;
					end
				end
			end
			ST_CLR: begin
				if (r_reg.cnt == 16'h0000) begin
					r_next.st = ST_IDLE;
					r_next.cpuHalt = 1'b0;
				end else begin
					r_next.cnt = r_reg.cnt - 16'h0001;
				end
			end
			ST_ARRAY: begin
				if (arrayDone && r_reg.erThenProg) begin
					r_next.erThenProg = 1'b0;
					r_next.arrayReq = 1'b1;
					r_next.arrayOp = OP_PAGE_PROGRAM;
				end else if (arrayDone) begin
					r_next.st = ST_IDLE;
					r_next.flash_busy_flag = 1'b0;
					r_next.eeprom_busy_flag = 1'b0;
					r_next.cpuHalt = 1'b0;
					r_next.readStall = 1'b0;
					r_next.bodHold = 1'b0;
					clrBuf = 1'b1;
				end
			end
			default: r_next.st = ST_IDLE;
		endcase
		if (launch) begin
			r_next.st = ST_ARRAY;
			r_next.arrayReq = 1'b1;
			r_next.arrayOp = launchOp;
			r_next.arrayKind = launchKind;
			r_next.arrayAddr = (launchOp == OP_FUSE) ?
				r_reg.addrWord : r_reg.bufPage;
			r_next.arrayMask = marks;
			r_next.readStall = 1'b1;
			r_next.arrayKeepEe = fuses.keepEeprom;
			r_next.bodHold = (launchOp == OP_FULL) &&
				fuses.brownoutEnabled;
			r_next.flash_busy_flag = launchKind == KIND_FLASH ||
				launchOp == OP_FUSE;
			r_next.eeprom_busy_flag = launchKind == KIND_EEPROM ||
				launchKind == KIND_ROW ||
				(launchOp == OP_FULL && !fuses.keepEeprom);
			// EEPROM and user row page work lets the core run on; anything else stops it.
			r_next.cpuHalt = r_next.flash_busy_flag ||
				launchOp == OP_EEPROM_ALL;
		end
		if (clrBuf) begin
			r_next.bufKind = KIND_NONE;
			r_next.bufMixed = 1'b0;
		end
		// Hardware setting wins over a software clear in the same cycle.
		r_next.readyFlag = !r_next.eeprom_busy_flag ||
			(r_reg.readyFlag && !clearReady);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r_reg <= RESET_STATE;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	for (genvar i = 0; i < `PAGE_BYTES; i++) begin : gBuf
		page_buffer_byte uByte (
			.clk(clk),
			.nrst(nrst),
			.clear(clrBuf),
			.load(bufLoad[i]),
			.din(store.data),
			.dout(bufBytes[i]),
			.marked(marks[i])
		);
	end

	assign awready = r_reg.awready;
	assign wready = r_reg.wready;
	assign bvalid = r_reg.bvalid;
	assign bresp = r_reg.bresp;
	assign arready = r_reg.arready;
	assign rvalid = r_reg.rvalid;
	assign rdata = r_reg.rdata;
	assign rresp = r_reg.rresp;
	assign cpuHalt = r_reg.cpuHalt;
	assign readStall = r_reg.readStall;
	assign loaderBlocked = r_reg.lockActive;
	assign bodHold = r_reg.bodHold;
	assign arrayReq = r_reg.arrayReq;
	assign arrayOp = r_reg.arrayOp;
	assign arrayKind = r_reg.arrayKind;
	assign arrayAddr = r_reg.arrayAddr;
	assign arrayWord = r_reg.dataWord;
	assign arrayMask = r_reg.arrayMask;
	assign arrayData = r_reg.arrayData;
	assign arrayKeepEe = r_reg.arrayKeepEe;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_clear_halt_seven:
	assert property (r_reg.st == ST_IDLE && cmdGo && !wakeUp &&
		cmd == CMD_BUFFER_RESET |=> cpuHalt [*7] ##1 !cpuHalt)
	else $error("Buffer reset halt is not seven cycles.");

	a_holdoff_busy_both:
	assert property (r_reg.st == ST_HOLD |-> r_reg.flash_busy_flag && r_reg.eeprom_busy_flag
		&& !arrayReq)
	else $error("Busy flags low during holdoff.");

	a_stall_during_op:
	assert property (r_reg.st == ST_ARRAY |-> readStall)
	else $error("Loads not stalled during array operation.");

	a_data_no_write:
	assert property (r_reg.st == ST_IDLE && !wakeUp && !cmdGo &&
		store.valid && stKind != KIND_NONE && !dbgActive &&
		execSec == SEC_DATA |=> r_reg.fault && $stable(marks))
	else $error("Store from data section was not refused.");

	a_ready_while_idle:
	assert property (!r_reg.eeprom_busy_flag |-> r_reg.readyFlag)
	else $error("Ready flag low while EEPROM idle.");

	a_fuse_debug_only:
	assert property (arrayReq && arrayOp == OP_FUSE && $rose(arrayReq)
		|-> $past(dbgActive))
	else $error("Fuse programming started without debug access.");

	a_lock_after_leave:
	assert property (r_reg.lockPend && execSec != SEC_LOADER
		|=> loaderBlocked)
	else $error("Loader lock did not take effect.");

	a_wipe_needs_mark:
	assert property (arrayReq && arrayOp == OP_PAGE_ERASE
		|-> arrayMask != 32'h0000_0000)
	else $error("Page wipe issued with empty buffer.");

	a_done_clears_busy:
	assert property (r_reg.st == ST_ARRAY && arrayDone &&
		!r_reg.erThenProg |=> !r_reg.flash_busy_flag && !r_reg.eeprom_busy_flag &&
		!cpuHalt && marks == '0)
	else $error("Completion did not release busy and buffer.");

	c_page_program:
	cover property (arrayReq && arrayOp == OP_PAGE_PROGRAM);
	c_wipe_then_program:
	cover property (arrayReq && arrayOp == OP_PAGE_ERASE ##[1:50]
		arrayReq && arrayOp == OP_PAGE_PROGRAM);
	c_full_wipe:
	cover property (arrayReq && arrayOp == OP_FULL && bodHold);
	c_buffer_reset:
	cover property (r_reg.st == ST_CLR && r_reg.cnt == 16'h0000);

endmodule

// ### test/array_model.sv
module array_model
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic arrayReq,
	input wire logic [7:0] arrayData,
	output logic arrayDone,
	output logic [4:0] arrayIdx
);
	timeunit 1ns;
	timeprecision 1ns;
	////////////////////////////////////////
	// Every step sweeps the whole buffer, so it finishes only after the
	// last byte has come back; that makes each step take 34 cycles.
	int reqCount;
	logic [7:0] got [32];
	logic run;
	logic [5:0] n;
	always @(posedge clk or negedge nrst) begin
		arrayDone <= 1'b0;
		if (!nrst) begin
			run <= 1'b0;
			n <= 6'h00;
			arrayIdx <= 5'h00;
			reqCount <= 0;
		end else if (arrayReq) begin
			run <= 1'b1;
			n <= 6'h00;
			reqCount <= reqCount + 1;
		end else if (run) begin
			n <= n + 6'h01;
			arrayIdx <= n[4:0];
			if (n >= 6'h02)
				got[n - 6'h02] <= arrayData;
			if (n == 6'h21) begin
				run <= 1'b0;
				arrayDone <= 1'b1;
			end
		end
	end
endmodule

// ### test/nonvolatile_memory_sequencer_tb.sv
`define CHK(a, b) begin \
	totalChecks++; \
	if ((a) !== (b)) begin \
		badCount++; \
		$display("ERROR %0t got %h want %h", $time, (a), (b)); \
	end \
end

module nonvolatile_memory_sequencer_tb
	import nvm_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic porReset, dbgActive, deviceLocked, wakeUp, arrayDone;
	logic awready, wready, bvalid, arready, rvalid, cpuHalt, readStall;
	logic loaderBlocked, bodHold, arrayReq, arrayKeepEe, lastKeep;
	logic [7:0] awaddr, araddr, arrayData;
	logic [31:0] wdata, rdata, arrayMask, lastMask;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic [12:0] pcOff;
	logic [4:0] arrayIdx;
	logic [15:0] arrayAddr, arrayWord;
	fuse_s fuses;
	store_s store;
	array_op_e arrayOp, lastOp;
	mem_kind_e arrayKind;
	int badCount, totalChecks, cyc, haltCnt, haltLast, n0;
	logic [31:0] d;

	nonvolatile_memory_sequencer #(.HOLDOFF_CYCLES(8)) u_dut (.clk, .nrst,
		.awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp, .fuses, .porReset, .dbgActive,
		.deviceLocked, .wakeUp, .pcOff, .store, .arrayDone, .arrayIdx,
		.cpuHalt, .readStall, .loaderBlocked, .bodHold, .arrayReq,
		.arrayOp, .arrayKind, .arrayAddr, .arrayWord, .arrayMask,
		.arrayData, .arrayKeepEe);
	array_model u_arr (.clk, .nrst, .arrayReq, .arrayData, .arrayDone,
		.arrayIdx);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	////////////////////////////////////////
	// The timeout is far above the fewer than a thousand cycles the run needs.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			badCount++;
			finishTest();
		end
	end
	always @(posedge clk) begin
		if (arrayReq === 1'b1) begin
			lastOp <= arrayOp;
			lastMask <= arrayMask;
			lastKeep <= arrayKeepEe;
		end
		if (cpuHalt === 1'b1)
			haltCnt <= haltCnt + 1;
		else begin
			if (haltCnt != 0)
				haltLast <= haltCnt;
			haltCnt <= 0;
		end
	end
	////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		rsp = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		v = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic cmd(input logic [2:0] c);
		wr(8'h28, 32'h5a);
		wr(8'h00, {29'h0, c});
	endtask
	task automatic st(input logic [15:0] a, input logic [7:0] v);
		store <= '{1'b1, a, v};
		@(posedge clk);
		store.valid <= 1'b0;
		@(posedge clk);
	endtask
	task automatic idle();
		forever begin
			rd(8'h08, d);
			if (d[1:0] === 2'b00)
				break;
		end
	endtask
	task automatic finishTest();
		$display("checks %0d errors %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////
	task automatic t_start();
		rd(8'h08, d);
		`CHK(d[1:0], 2'b11)
		rd(8'h0c, d);
		`CHK(rsp, 2'h2)
		idle();
		`CHK(d[1:0], 2'b00)
	endtask
	task automatic t_flash();
		n0 = u_arr.reqCount;
		st(16'h8403, 8'hf0);
		st(16'h8403, 8'h3c);
		cmd(3'h3);
		`CHK(cpuHalt, 1'b1)
		`CHK(readStall, 1'b1)
		idle();
		`CHK(u_arr.reqCount - n0, 2)
		`CHK(lastOp, OP_PAGE_PROGRAM)
		`CHK(arrayAddr, 16'h8400)
		`CHK(arrayKind, KIND_FLASH)
		`CHK(u_arr.got[3], 8'h30)
		`CHK(lastMask, 32'h8)
	endtask
	task automatic t_eeprom();
		st(16'h1405, 8'haa);
		cmd(3'h1);
		`CHK(cpuHalt, 1'b0)
		`CHK(readStall, 1'b1)
		st(16'h1406, 8'h00);
		idle();
		`CHK(lastMask, 32'h20)
		`CHK(u_arr.got[5], 8'haa)
		rd(8'h10, d);
		`CHK(d[0], 1'b1)
		st(16'h1401, 8'h11);
		cmd(3'h2);
		idle();
		`CHK(lastMask, 32'h2)
		`CHK(lastOp, OP_PAGE_ERASE)
	endtask
	task automatic t_guard();
		n0 = u_arr.reqCount;
		st(16'h8401, 8'h00);
		cmd(3'h4);
		repeat (10) @(posedge clk);
		`CHK(haltLast, 7)
		cmd(3'h2);
		st(16'h8402, 8'h00);
		wr(8'h00, 32'h1);
		wr(8'h28, 32'h5a);
		repeat (6) @(posedge clk);
		wr(8'h00, 32'h1);
		idle();
		`CHK(u_arr.reqCount - n0, 0)
	endtask
	task automatic t_sections();
		n0 = u_arr.reqCount;
		pcOff <= 13'h0900;
		st(16'h1401, 8'h00);
		cmd(3'h1);
		rd(8'h08, d);
		`CHK(d[2], 1'b1)
		`CHK(u_arr.reqCount - n0, 0)
		pcOff <= 13'h0500;
		cmd(3'h4);
		// The core is halted through the clear, so no store comes early.
		repeat (8) @(posedge clk);
		st(16'h1402, 8'h00);
		cmd(3'h1);
		idle();
		`CHK(u_arr.reqCount - n0, 1)
	endtask
	task automatic t_protect();
		n0 = u_arr.reqCount;
		pcOff <= 13'h0000;
		wr(8'h28, 32'ha5);
		wr(8'h04, 32'h3);
		st(16'h8410, 8'h00);
		cmd(3'h1);
		`CHK(u_arr.reqCount - n0, 0)
		`CHK(loaderBlocked, 1'b0)
		pcOff <= 13'h0500;
		repeat (3) @(posedge clk);
		`CHK(loaderBlocked, 1'b1)
		cmd(3'h6);
		`CHK(cpuHalt, 1'b1)
		idle();
		`CHK(lastOp, OP_EEPROM_ALL)
		cmd(3'h5);
		`CHK(bodHold, 1'b1)
		idle();
		`CHK(lastOp, OP_FULL)
		`CHK(lastKeep, 1'b1)
	endtask
	task automatic t_fuse();
		n0 = u_arr.reqCount;
		wr(8'h20, 32'h2);
		wr(8'h18, 32'h55);
		`CHK(rsp, 2'h0)
		cmd(3'h7);
		`CHK(u_arr.reqCount - n0, 0)
		dbgActive <= 1'b1;
		cmd(3'h7);
		idle();
		`CHK(lastOp, OP_FUSE)
		`CHK(arrayAddr, 16'h0002)
		`CHK(arrayWord, 16'h0055)
		deviceLocked <= 1'b1;
		st(16'h8410, 8'h00);
		rd(8'h08, d);
		`CHK(d[2], 1'b1)
		st(16'h1301, 8'h42);
		cmd(3'h1);
		idle();
		`CHK(lastMask, 32'h2)
		`CHK(arrayKind, KIND_ROW)
		deviceLocked <= 1'b0;
		n0 = u_arr.reqCount;
		st(16'h1402, 8'h00);
		wakeUp <= 1'b1;
		@(posedge clk);
		wakeUp <= 1'b0;
		cmd(3'h1);
		idle();
		`CHK(u_arr.reqCount - n0, 0)
		dbgActive <= 1'b0;
	endtask
	task automatic t_skip();
		fuses.holdoffDisable <= 1'b0;
		nrst <= 1'b0;
		@(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(8'h08, d);
		`CHK(d[1:0], 2'b00)
	endtask
	////////////////////////////////////////
	initial begin
		{nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
		{dbgActive, deviceLocked, wakeUp, awaddr, araddr} = '0;
		{wdata, wstrb, pcOff, store} = '0;
		porReset = 1'b1;
		fuses = '{8'h04, 8'h08, 1'b1, 1'b1, 1'b0, 1'b1};
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		t_start();
		t_flash();
		t_eeprom();
		t_guard();
		t_sections();
		t_protect();
		t_fuse();
		t_skip();
		finishTest();
	end
endmodule
